//--- hw/aht_pkg.sv
// Shared constants and types for the acquisition hardware trigger unit.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
package aht_pkg;

  // Clock period in picoseconds.
  localparam int unsigned CLK_PERIOD_PS = 5000;
  // Width of the glitch filter length field.
  localparam int unsigned FILT_W = 8;
  // Width of the edge count field.
  localparam int unsigned EDGE_W = 8;
  // Width of the sequence count field.
  localparam int unsigned SEQ_W = 16;
  // Most channels in one sequence list.
  localparam int unsigned MAX_CH = 16;
  // Width of one channel number.
  localparam int unsigned CH_W = 4;
  // Width of the list length field, which holds 1 to 16.
  localparam int unsigned LEN_W = 5;
  // Reset values of counters.
  localparam logic [EDGE_W-1:0] EDGE_RST = 8'h00;
  localparam logic [SEQ_W-1:0] SEQ_RST = 16'h0000;
  localparam logic [FILT_W-1:0] FILT_RST = 8'h00;
  localparam logic [CH_W-1:0] CH_RST = 4'h0;

  // Acquisition modes selected by software.
  typedef enum logic [1:0] {
    AHT_ACQ_AUTO,
    AHT_ACQ_SEQ,
    AHT_ACQ_MINMAX,
    AHT_ACQ_OFF
  } aht_acq_mode_t;

  // Which trigger edges count.
  typedef enum logic [1:0] {
    AHT_EDGE_RISE,
    AHT_EDGE_FALL,
    AHT_EDGE_BOTH,
    AHT_EDGE_NONE
  } aht_edge_sel_t;

  // Software configuration carried as one bundle.
  typedef struct packed {
    aht_acq_mode_t acq_mode;
    aht_edge_sel_t edge_sel;
    logic filt_en;
    logic [FILT_W-1:0] filt_len;
    logic [EDGE_W-1:0] edges_needed;
    logic one_shot;
    logic [SEQ_W-1:0] seq_count;
    logic [LEN_W-1:0] list_len;
    logic [MAX_CH*CH_W-1:0] ch_list;
  } aht_cfg_t;

endpackage : aht_pkg

//--- hw/aht_filter.sv
// Glitch filter and edge detector for the external trigger pin.
// Assumes the pin is asynchronous to clk; it passes three flip-flops first.
`timescale 1ns/10ps
module aht_filter (
  input wire logic clk,
  input wire logic srst,
  input wire logic trig_pin,
  input wire logic filt_en,
  input wire logic [aht_pkg::FILT_W-1:0] filt_len,
  input wire aht_pkg::aht_edge_sel_t edge_sel,
  output logic edge_seen
);
  import aht_pkg::*;

  logic [2:0] sync_q;
  logic level_q;
  logic [FILT_W-1:0] stable_q;
  logic [FILT_W-1:0] stable_d;
  logic agree;
  logic differs;
  logic accept;
  logic rise;
  logic fall;

  // Synchroniser; only the agreement of stages two and three is used.
  always_ff @(posedge clk) begin
    if (srst) begin
      sync_q <= 3'b000;
    end else begin
      sync_q <= {sync_q[1:0], trig_pin};
    end
  end

  // A new level must hold filt_len cycles before it is accepted.
  assign agree = (sync_q[1] == sync_q[2]);
  assign differs = agree && (sync_q[2] != level_q);
  assign stable_d = differs ? stable_q + 8'h01 : FILT_RST;
  assign accept = differs && (!filt_en || stable_q >= filt_len);

  always_ff @(posedge clk) begin
    if (srst) begin
      stable_q <= FILT_RST;
      level_q <= 1'b0;
    end else begin
      stable_q <= accept ? FILT_RST : stable_d;
      if (accept) begin
        level_q <= sync_q[2];
      end
    end
  end

  // Edge selection on the filtered level.
  assign rise = accept && sync_q[2];
  assign fall = accept && !sync_q[2];
  assign edge_seen = (edge_sel == AHT_EDGE_RISE && rise) ||
                     (edge_sel == AHT_EDGE_FALL && fall) ||
                     (edge_sel == AHT_EDGE_BOTH && accept);

  // A filtered transition needs the raw level to stay put for the count.
  // A length of zero accepts on the first agreeing cycle, so it is left out here.
  filt_hold_a: assert property (@(posedge clk) disable iff (srst)
    (accept && filt_en && filt_len != FILT_RST) |-> $stable(sync_q[2]) && agree)
    else $error("Filtered edge accepted on an unstable input.");

endmodule : aht_filter

//--- hw/aht_trigger.sv
// Hardware trigger unit: edge counting, one-shot and sequence modes,
// and the channel list stepper that drives the acquisition sequencer.
// Assumes the sequencer answers each channel request with conv_done.
`timescale 1ns/10ps
module aht_trigger (
  input wire logic clk,
  input wire logic srst,
  input wire logic trig_pin,
  input wire aht_pkg::aht_cfg_t cfg,
  input wire logic sw_start,
  input wire logic sw_stop,
  input wire logic conv_done,
  output logic conv_req,
  output logic [aht_pkg::CH_W-1:0] conv_ch,
  output logic armed,
  output logic busy,
  output logic trig_action,
  output logic [aht_pkg::EDGE_W-1:0] edge_cnt
);
  import aht_pkg::*;

  typedef enum logic [1:0] {
    AHT_IDLE,
    AHT_WAIT,
    AHT_RUN,
    AHT_DONE
  } aht_state_t;

  aht_state_t state_q;
  aht_state_t state_d;
  logic [EDGE_W-1:0] edge_q;
  logic [EDGE_W-1:0] edge_d;
  logic [SEQ_W-1:0] seq_q;
  logic [SEQ_W-1:0] seq_d;
  logic [LEN_W-1:0] idx_q;
  logic [LEN_W-1:0] idx_d;
  logic req_q;
  logic [CH_W-1:0] ch_q;
  logic [CH_W-1:0] list_ch [MAX_CH];
  logic edge_seen;
  logic mode_ok;
  logic edge_use;
  logic fire;
  logic last_ch;
  logic last_seq;
  logic [LEN_W-1:0] len_eff;

  aht_filter u_filter (
    .clk(clk),
    .srst(srst),
    .trig_pin(trig_pin),
    .filt_en(cfg.filt_en),
    .filt_len(cfg.filt_len),
    .edge_sel(cfg.edge_sel),
    .edge_seen(edge_seen)
  );

  // Unpack the channel list; entry 0 sits in the lowest nibble.
  for (genvar i = 0; i < MAX_CH; i++) begin : g_list
    assign list_ch[i] = cfg.ch_list[i*CH_W +: CH_W];
  end

  // Trigger qualification and edge counting.
  assign mode_ok = (cfg.acq_mode == AHT_ACQ_AUTO) || (cfg.acq_mode == AHT_ACQ_SEQ);
  assign edge_use = edge_seen && (state_q == AHT_WAIT) && mode_ok;
  // An edge count of zero is treated as one, so a trigger can always fire.
  assign fire = edge_use && (edge_q + 8'h01 >= cfg.edges_needed);
  assign edge_d = (sw_start || fire) ? EDGE_RST :
                  edge_use ? edge_q + 8'h01 : edge_q;

  // Channel list walk; a list length of zero is taken as one entry.
  assign len_eff = (cfg.list_len == 5'h00) ? 5'h01 :
                   (cfg.list_len > 5'h10) ? 5'h10 : cfg.list_len;
  assign last_ch = (idx_q + 5'h01 >= len_eff);
  assign last_seq = (cfg.seq_count != SEQ_RST) && (seq_q + 16'h0001 >= cfg.seq_count);

  // Next state: stop always wins, start re-arms from any state.
  always_comb begin
    state_d = state_q;
    seq_d = seq_q;
    idx_d = idx_q;
    unique case (state_q)
      AHT_IDLE: begin
      end
      AHT_WAIT: begin
        if (fire) begin
          state_d = AHT_RUN;
          seq_d = SEQ_RST;
          idx_d = 5'h00;
        end
      end
      AHT_RUN: begin
        if (conv_done) begin
          idx_d = last_ch ? 5'h00 : idx_q + 5'h01;
          if (last_ch) begin
            seq_d = seq_q + 16'h0001;
            if (last_seq) begin
              state_d = cfg.one_shot ? AHT_DONE : AHT_WAIT;
            end
          end
        end
      end
      AHT_DONE: begin
      end
    endcase
    if (sw_start) begin
      state_d = AHT_WAIT;
      idx_d = 5'h00;
      seq_d = SEQ_RST;
    end
    if (sw_stop) begin
      state_d = AHT_IDLE;
    end
  end

  // State and counters.
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= AHT_IDLE;
      edge_q <= EDGE_RST;
      seq_q <= SEQ_RST;
      idx_q <= 5'h00;
    end else begin
      state_q <= state_d;
      edge_q <= edge_d;
      seq_q <= seq_d;
      idx_q <= idx_d;
    end
  end

  // Conversion request and channel number from flip-flops.
  always_ff @(posedge clk) begin
    if (srst) begin
      req_q <= 1'b0;
      ch_q <= CH_RST;
    end else begin
      req_q <= (state_d == AHT_RUN);
      ch_q <= list_ch[idx_d[CH_W-1:0]];
    end
  end

  assign conv_req = req_q;
  assign conv_ch = ch_q;
  assign armed = (state_q == AHT_WAIT);
  assign busy = (state_q == AHT_RUN);
  assign trig_action = fire;
  assign edge_cnt = edge_q;

  // No trigger action outside the two allowed acquisition modes.
  // Checked against the raw mode field so a broken decode would show.
  mode_gate_a: assert property (@(posedge clk) disable iff (srst)
    trig_action |-> armed && (cfg.acq_mode == AHT_ACQ_AUTO || cfg.acq_mode == AHT_ACQ_SEQ))
    else $error("Trigger action in a disallowed mode or state.");

  // Action moves the unit into acquisition on the next edge.
  fire_run_a: assert property (@(posedge clk) disable iff (srst)
    (trig_action && !sw_start && !sw_stop) |=> busy && edge_cnt == EDGE_RST)
    else $error("Trigger action did not start acquisition.");

  // Edge count never moves while acquiring.
  busy_hold_a: assert property (@(posedge clk) disable iff (srst)
    (busy && $past(busy) && !$past(sw_start)) |-> $stable(edge_cnt))
    else $error("Edge counter moved during acquisition.");

  // Start clears the edge count.
  start_clr_a: assert property (@(posedge clk) disable iff (srst)
    sw_start |=> edge_cnt == EDGE_RST)
    else $error("Software start did not clear the edge counter.");

  // One-shot completion never returns to waiting by itself.
  one_shot_a: assert property (@(posedge clk) disable iff (srst)
    (state_q == AHT_DONE && !sw_start) |=> !armed && !busy)
    else $error("One-shot unit re-armed without a start.");

  // One-shot mode parks after its sequences instead of re-arming.
  shot_park_a: assert property (@(posedge clk) disable iff (srst)
    (busy && conv_done && last_ch && last_seq && cfg.one_shot && !sw_start && !sw_stop)
      |=> state_q == AHT_DONE && !conv_req)
    else $error("One-shot unit did not park after its sequences.");

  // Sequence mode re-arms after the last sequence.
  seq_rearm_a: assert property (@(posedge clk) disable iff (srst)
    (busy && conv_done && last_ch && last_seq && !cfg.one_shot && !sw_start && !sw_stop)
      |=> armed)
    else $error("Sequence mode did not re-arm.");

  // Continuous mode only leaves acquisition on stop or start.
  cont_run_a: assert property (@(posedge clk) disable iff (srst)
    (busy && cfg.seq_count == SEQ_RST && !sw_stop && !sw_start) |=> busy)
    else $error("Continuous acquisition ended without a stop.");

  // Channel index stays inside the programmed list.
  list_bound_a: assert property (@(posedge clk) disable iff (srst)
    busy |-> idx_q < len_eff)
    else $error("Channel index left the programmed list.");

  // Every acquisition starts at the head of the channel list.
  list_head_a: assert property (@(posedge clk) disable iff (srst)
    $rose(conv_req) |-> conv_ch == list_ch[0])
    else $error("Acquisition did not start at the first list entry.");

  // Stop returns the unit to idle.
  stop_idle_a: assert property (@(posedge clk) disable iff (srst)
    sw_stop |=> !armed && !busy && !conv_req)
    else $error("Stop did not idle the unit.");

  fire_c: cover property (@(posedge clk) disable iff (srst) trig_action);
  rearm_c: cover property (@(posedge clk) disable iff (srst) busy ##1 armed);
  done_c: cover property (@(posedge clk) disable iff (srst) busy ##1 state_q == AHT_DONE);
  drop_c: cover property (@(posedge clk) disable iff (srst) busy && edge_seen);
  stop_c: cover property (@(posedge clk) disable iff (srst) busy && sw_stop);

endmodule : aht_trigger

//--- bench/aht_seq_model.sv
// Behavioural acquisition sequencer that answers each conversion request.
// Assumes conv_req stays high until the matching conv_done has been seen.
`timescale 1ns/10ps
module aht_seq_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic conv_req,
  input wire logic [31:0] lat,
  output logic conv_done
);
  int cnt_q;
  // Done comes lat cycles after the request and only while it is asked for.
  // A latency of zero would answer before conv_ch moves, so use one or more.
  assign conv_done = conv_req && (cnt_q == lat);
  // Restart the count after each answer so every channel pays the full latency.
  always_ff @(posedge clk) begin
    if (srst || !conv_req || conv_done) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule : aht_seq_model

//--- bench/aht_trigger_tb_top.sv
// Self-checking testbench for the hardware trigger unit.
// Assumes the sequencer model answers conversions; the bench drives the pin.
`timescale 1ns/10ps
module aht_trigger_tb_top;
  import aht_pkg::*;
  logic clk, srst, trig_pin, sw_start, sw_stop, conv_done, conv_req;
  logic armed, busy, trig_action;
  logic [CH_W-1:0] conv_ch;
  logic [EDGE_W-1:0] edge_cnt;
  aht_cfg_t cfg;
  int lat, bad_count, n_checks, n_act;
  logic [CH_W-1:0] got[$];
  aht_trigger dut (.clk(clk), .srst(srst), .trig_pin(trig_pin), .cfg(cfg),
    .sw_start(sw_start), .sw_stop(sw_stop), .conv_done(conv_done), .conv_req(conv_req),
    .conv_ch(conv_ch), .armed(armed), .busy(busy), .trig_action(trig_action),
    .edge_cnt(edge_cnt));
  aht_seq_model seq (.clk(clk), .srst(srst), .conv_req(conv_req), .lat(lat),
    .conv_done(conv_done));
  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Trigger actions and converted channels are logged as they happen.
  always @(posedge clk) begin
    if (trig_action === 1'b1) n_act++;
    if (conv_done === 1'b1) got.push_back(conv_ch);
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, m, g, e);
    end
  endtask : chk
  // Twenty cycles covers the synchroniser and the longest filter used here.
  task automatic pin(input logic v);
    trig_pin = v;
    step(20);
  endtask : pin
  task automatic pulse();
    pin(1'b1);
    pin(1'b0);
  endtask : pulse
  task automatic setup(input aht_acq_mode_t m, input aht_edge_sel_t e, input int need,
                       input logic os, input int sc);
    cfg = '0;
    cfg.acq_mode = m;
    cfg.edge_sel = e;
    cfg.edges_needed = EDGE_W'(need);
    cfg.one_shot = os;
    cfg.seq_count = SEQ_W'(sc);
    cfg.list_len = 5'h02;
    cfg.ch_list = 64'h0000_0000_0000_0052;
    sw_start = 1'b1;
    step(1);
    sw_start = 1'b0;
    step(2);
    n_act = 0;
    got.delete();
  endtask : setup
  task automatic wait_idle();
    for (int i = 0; i < 400 && busy !== 1'b0; i++) step(1);
    if (busy !== 1'b0) begin
      bad_count++;
      $display("unexpected at %0t: acquisition never ended", $time);
    end
  endtask : wait_idle
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  // Watchdog: the whole sequence needs well under 10 us.
  initial begin
    #100us;
    bad_count++;
    complete_run();
  end
  initial begin
    {srst, trig_pin, sw_start, sw_stop} = 4'h8;
    cfg = '0;
    lat = 20;
    step(10);
    srst = 1'b0;
    step(1);
    chk({armed, busy, conv_req, edge_cnt}, 0, "reset state");
    // Two channels, two sequences per action, three edges needed.
    setup(AHT_ACQ_SEQ, AHT_EDGE_RISE, 3, 1'b0, 2);
    pulse();
    pulse();
    chk({n_act[7:0], edge_cnt}, 16'h0002, "two edges, no action");
    pin(1'b1);
    chk({n_act[7:0], edge_cnt}, 16'h0100, "action clears count");
    pulse();
    chk({3'b000, busy, n_act[3:0], edge_cnt}, 16'h1100, "edges during acquisition");
    wait_idle();
    chk(got.size(), 4, "sequences per action");
    for (int i = 0; i < 4; i++) chk(got[i], (i % 2) ? 5 : 2, "channel order");
    chk(armed, 1, "re-armed after sequences");
    pin(1'b0);
    pulse();
    chk(edge_cnt, 1, "counting again");
    setup(AHT_ACQ_SEQ, AHT_EDGE_RISE, 3, 1'b0, 2);
    chk(edge_cnt, 0, "start clears count");
    lat = 1;
    for (int e = 0; e < 3; e++) begin
      setup(AHT_ACQ_SEQ, aht_edge_sel_t'(e), 8, 1'b0, 1);
      pin(1'b1);
      chk(edge_cnt, e != 1, "after rising edge");
      pin(1'b0);
      chk(edge_cnt, (e == 2) ? 2 : 1, "after falling edge");
    end
    for (int m = 0; m < 4; m++) begin
      setup(aht_acq_mode_t'(m), AHT_EDGE_RISE, 1, 1'b1, 1);
      pulse();
      wait_idle();
      chk(n_act, m < 2, "trigger per acquisition mode");
    end
    setup(AHT_ACQ_SEQ, AHT_EDGE_RISE, 8, 1'b0, 1);
    cfg.filt_en = 1'b1;
    cfg.filt_len = 8'h0a;
    trig_pin = 1'b1;
    step(4);
    pin(1'b0);
    chk(edge_cnt, 0, "glitch filtered");
    pulse();
    chk(edge_cnt, 1, "long pulse passes filter");
    setup(AHT_ACQ_SEQ, AHT_EDGE_RISE, 1, 1'b1, 1);
    pulse();
    wait_idle();
    pulse();
    chk({2'b00, armed, busy, n_act[3:0], 8'(got.size())}, 16'h0102, "one shot ignores later");
    setup(AHT_ACQ_SEQ, AHT_EDGE_RISE, 1, 1'b0, 0);
    pulse();
    step(100);
    chk({busy, got.size() > 20}, 3, "continuous until stop");
    sw_stop = 1'b1;
    step(1);
    sw_stop = 1'b0;
    step(2);
    chk({busy, conv_req}, 0, "stopped");
    complete_run();
  end
endmodule : aht_trigger_tb_top
